// ### rtl/tiw_top.sv
// Timers, interrupt controller, standby/wake-up, real-time tick, oscillator control and watchdog

// Function
// RL1: Three 12-bit up-counting timers
// RL2: Wrap reloads preset and keeps counting
// RL3: Overflow requests interrupt only when enabled
// RL4: Writing zero clears the count
// RL5: Reading a running count never disturbs it
// RL6: External clock pin can clock timer_a
// RL7: Maskable request lines plus one non-maskable
// RL8: Maskable requests never preempt non-maskable service
// RL9: Fixed source-to-line priority assignment
// RL10: Port pin serves as external interrupt
// RL11: Wake enable then stop write halts CPU
// RL12: Standby holds RAM and pin states
// RL13: Port pins, tick, external pin wake
// RL14: Wake restarts CPU clock without reset
// RL15: Selectable 2 Hz or 8 Hz tick
// RL16: Auto mode: strong oscillator first second
// RL17: Watchdog resets after one uncleared second
// RL18: Build option removes the watchdog
// RL19: Pending flags stick until software clears
// RL20: Lowest pending enabled line presented first
module tiw_top
  import tiw_pkg::*;
#(
  parameter int unsigned WDT_CYCLES = TIW_WDT_CYCLES,
  parameter int unsigned OSC_STRONG_EDGES = TIW_OSC_STRONG_EDGES,
  parameter bit WDT_ENABLE = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [7:0] key_pins,
  input wire logic port_a_bit0_pin,
  input wire logic port_a_bit1_pin,
  input wire logic xtal_32k_in,
  input wire logic nmi_ack,
  input wire logic nmi_done,
  output logic irq_req,
  output logic [2:0] irq_num,
  output logic nmi_req,
  output logic cpu_clk_en,
  output logic io_hold,
  output logic osc_strong,
  output logic wdt_reset
);

  // ==========================================================================
  // Helpers
  function automatic logic div_wrap(input logic [13:0] cnt, input logic [13:0] mask);
    return (cnt & mask) == mask;
  endfunction

  // Lowest set bit wins, so request line 1 outranks line 8
  function automatic logic [2:0] lowest_line(input logic [7:0] req);
    logic [2:0] idx;
    idx = 3'h7;
    for (int i = 7; i >= 0; i--) begin
      if (req[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  logic [10:0] sync_1;
  logic [10:0] sync_2;
  logic [10:0] sync_3;
  logic [10:0] pin_stable;
  logic [13:0] xtal_div;
  logic [15:0] ctrl;
  logic [2:0] wake_en;
  logic [8:0] irq_en;
  logic [8:0] pend;
  logic nmi_active;
  logic [11:0] tmr_cnt [3];
  logic [11:0] tmr_pre [3];
  logic [27:0] wdt_cnt;
  logic [15:0] strong_cnt;
  tiw_pwr_t pwr_state;

  // A lane only moves once the last two stages agree, filtering a half-caught edge
  wire [10:0] sync_agree = ~(sync_2 ^ sync_3);
  wire [10:0] next_pin_stable = (sync_agree & sync_3) | (~sync_agree & pin_stable);
  wire [10:0] pin_rise = next_pin_stable & ~pin_stable;
  wire [10:0] pin_change = next_pin_stable ^ pin_stable;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_1 <= '0;
      sync_2 <= '0;
      sync_3 <= '0;
      pin_stable <= '0;
    end else begin
      sync_1 <= {xtal_32k_in, port_a_bit1_pin, port_a_bit0_pin, key_pins};
      sync_2 <= sync_1;
      sync_3 <= sync_2;
      pin_stable <= next_pin_stable;
    end
  end

  // ==========================================================================
  // Event sources
  wire key_event = |pin_change[7:0];
  wire external_pin_event = ctrl[TIW_CTRL_EXT_EN] & pin_rise[TIW_PIN_EXT]; // RL10
  wire ext_clock_in = pin_rise[TIW_PIN_ECK];
  wire xtal_edge = pin_rise[TIW_PIN_XTAL];
  wire tb1_event = xtal_edge & div_wrap(xtal_div, TIW_TB1_MASK);
  wire tb2_event = xtal_edge & div_wrap(xtal_div, TIW_TB2_MASK);
  wire [13:0] rtc_mask = ctrl[TIW_CTRL_RTC8] ? TIW_RTC8_MASK : TIW_RTC2_MASK; // RL15
  wire rtc_event = xtal_edge & div_wrap(xtal_div, rtc_mask); // RL15

  // Crystal divider feeds the time bases and the tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xtal_div <= '0;
    end else if (xtal_edge) begin
      xtal_div <= xtal_div + 14'h0001;
    end
  end

  // ==========================================================================
  // Register write decode
  wire ctrl_wr = reg_wr && (reg_addr == TIW_REG_CTRL);
  wire wake_wr = reg_wr && (reg_addr == TIW_REG_WAKE);
  wire inten_wr = reg_wr && (reg_addr == TIW_REG_INTEN);
  wire pend_wr = reg_wr && (reg_addr == TIW_REG_PEND);
  wire stop_wr = reg_wr && (reg_addr == TIW_REG_STOP);
  wire wdog_clr = reg_wr && (reg_addr == TIW_REG_WDOG);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl <= TIW_CTRL_RST;
      wake_en <= TIW_WAKE_RST;
      irq_en <= TIW_INTEN_RST;
    end else begin
      if (ctrl_wr) ctrl <= reg_wdata;
      if (wake_wr) wake_en <= reg_wdata[2:0];
      if (inten_wr) irq_en <= reg_wdata[8:0];
    end
  end

  // ==========================================================================
  // Timers
  // timer_a may follow the external clock pin, also with the feedback oscillator on
  wire tick_a = ctrl[TIW_CTRL_ECK] ? ext_clock_in : 1'b1; // RL6
  wire [2:0] tmr_tick = {ctrl[TIW_CTRL_RUN_C], ctrl[TIW_CTRL_RUN_B], ctrl[TIW_CTRL_RUN_A] & tick_a};
  logic [2:0] tmr_wr;
  logic [2:0] tmr_ovf;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_tmr
      assign tmr_wr[g] = reg_wr && (reg_addr == TIW_REG_TMA + 4'(g));
      assign tmr_ovf[g] = tmr_tick[g] && (tmr_cnt[g] == TIW_TMR_MAX); // RL2
    end
  endgenerate

  // A write loads the preset; a zero write also clears the running count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        tmr_cnt[i] <= TIW_TMR_RST;
        tmr_pre[i] <= TIW_TMR_RST;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tmr_wr[i]) begin
          tmr_pre[i] <= reg_wdata[11:0];
          if (reg_wdata[11:0] == TIW_TMR_RST) tmr_cnt[i] <= TIW_TMR_RST; // RL4
        end else if (tmr_ovf[i]) begin
          tmr_cnt[i] <= tmr_pre[i]; // RL2
        end else if (tmr_tick[i]) begin
          tmr_cnt[i] <= tmr_cnt[i] + 12'h001; // RL1
        end
      end
    end
  end

  // ==========================================================================
  // Interrupt controller
  // Line order: timer_a, timer_b, timer_c, time bases, tick, keys, external; bit 8 non-maskable
  wire [8:0] pend_set = {tmr_ovf[0], external_pin_event, key_event, rtc_event, tb2_event, tb1_event,
                         tmr_ovf[2:0]}; // RL9
  wire [8:0] pend_clr = pend_wr ? reg_wdata[8:0] : 9'h000;
  wire [8:0] next_pend = (pend & ~pend_clr) | pend_set; // RL19
  wire [7:0] irq_live = pend[7:0] & irq_en[7:0]; // RL3
  wire next_irq_req = (|irq_live) & ~nmi_active; // RL8
  wire [2:0] next_irq_num = lowest_line(irq_live); // RL20
  wire next_nmi_req = pend[TIW_NMI_BIT] & irq_en[TIW_NMI_BIT]; // RL7

  // Set wins over clear so an event landing on a clear write is kept
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend <= '0;
      nmi_active <= 1'b0;
      irq_req <= 1'b0;
      irq_num <= 3'h0;
      nmi_req <= 1'b0;
    end else begin
      pend <= next_pend;
      nmi_active <= nmi_ack | (nmi_active & ~nmi_done);
      irq_req <= next_irq_req;
      irq_num <= next_irq_num;
      nmi_req <= next_nmi_req;
    end
  end

  // ==========================================================================
  // Standby and wake-up
  wire wake_hit = (wake_en[TIW_WAKE_KEY] & key_event) | (wake_en[TIW_WAKE_RTC] & rtc_event) |
                  (wake_en[TIW_WAKE_EXT] & pin_rise[TIW_PIN_EXT]); // RL13
  tiw_pwr_t next_pwr_state;

  always_comb begin
    next_pwr_state = pwr_state;
    unique case (pwr_state)
      TIW_RUN: if (stop_wr && (|wake_en)) next_pwr_state = TIW_STANDBY; // RL11
      TIW_STANDBY: if (wake_hit) next_pwr_state = TIW_RUN; // RL14
    endcase
  end

  // Only the clock gate and the pin hold move; state elsewhere is untouched, so code resumes in place
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pwr_state <= TIW_RUN;
      cpu_clk_en <= 1'b1;
      io_hold <= 1'b0;
    end else begin
      pwr_state <= next_pwr_state;
      cpu_clk_en <= (next_pwr_state == TIW_RUN); // RL14
      io_hold <= (next_pwr_state == TIW_STANDBY); // RL12
    end
  end

  // ==========================================================================
  // Oscillator drive: strong for the first second, then weak in auto mode
  wire strong_done = (strong_cnt == 16'(OSC_STRONG_EDGES));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strong_cnt <= '0;
      osc_strong <= 1'b1;
    end else begin
      if (xtal_edge && !strong_done) strong_cnt <= strong_cnt + 16'h0001;
      osc_strong <= ~ctrl[TIW_CTRL_AUTO] | ~strong_done; // RL16
    end
  end

  // ==========================================================================
  // Watchdog; the reset pulse is one cycle, the system reset logic stretches it
  wire wdt_expire = WDT_ENABLE && (wdt_cnt == 28'(WDT_CYCLES - 1)); // RL18

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdt_cnt <= '0;
      wdt_reset <= 1'b0;
    end else begin
      wdt_cnt <= (wdog_clr || wdt_expire) ? 28'h000_0000 : wdt_cnt + 28'h000_0001;
      wdt_reset <= wdt_expire && !wdog_clr; // RL17
    end
  end

  // ==========================================================================
  // Read path; counts are read live, never latched or paused
  logic [15:0] rd_sel;

  always_comb begin
    rd_sel = 16'h0000;
    unique case (reg_addr)
      TIW_REG_TMA: rd_sel = {4'h0, tmr_cnt[0]}; // RL5
      TIW_REG_TMB: rd_sel = {4'h0, tmr_cnt[1]};
      TIW_REG_TMC: rd_sel = {4'h0, tmr_cnt[2]};
      TIW_REG_INTEN: rd_sel = {7'h00, irq_en};
      TIW_REG_PEND: rd_sel = {7'h00, pend};
      TIW_REG_CTRL: rd_sel = ctrl;
      TIW_REG_WAKE: rd_sel = {13'h0000, wake_en};
      TIW_REG_STAT: rd_sel = {9'h000, irq_num, nmi_active, irq_req, osc_strong, io_hold};
      default: rd_sel = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_sel : 16'h0000;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_stop;
    stop_wr && (|wake_en) && (pwr_state == TIW_RUN);
  endsequence

  sequence s_halted;
    !cpu_clk_en && io_hold;
  endsequence

  a_tmr_reload: assert property (tmr_ovf[0] && !tmr_wr[0] |=> tmr_cnt[0] == $past(tmr_pre[0])) // RL2
    else $error("timer_a did not reload its preset");
  a_tmr_count: assert property (tmr_tick[1] && !tmr_wr[1] && !tmr_ovf[1]
    |=> tmr_cnt[1] == 12'($past(tmr_cnt[1]) + 12'h001)) // RL1
    else $error("timer_b did not count up");
  a_zero_clear: assert property (tmr_wr[1] && reg_wdata[11:0] == 12'h000 |=> tmr_cnt[1] == 12'h000) // RL4
    else $error("zero write did not clear count");
  a_read_quiet: assert property (reg_rd && !tmr_wr[2] && !tmr_tick[2] |=> $stable(tmr_cnt[2])) // RL5
    else $error("read disturbed timer_c");
  a_irq_enable: assert property (irq_req |-> |($past(pend[7:0]) & $past(irq_en[7:0]))) // RL3
    else $error("request raised without enabled source");
  a_nmi_block: assert property (nmi_active && !nmi_done |=> nmi_active ##0 !irq_req ##1 !irq_req) // RL8
    else $error("maskable request during non-maskable service");
  a_irq_lowest: assert property (irq_req
    |-> ($past(irq_live) & 8'((9'h001 << irq_num) - 9'h001)) == 8'h00) // RL20
    else $error("higher line skipped");
  a_pend_sticky: assert property (pend[3] && !pend_clr[3] |=> pend[3]) // RL19
    else $error("pending flag lost");
  a_stop_enter: assert property (s_stop |=> s_halted) // RL11
    else $error("stop write did not halt");
  a_wake_resume: assert property ((pwr_state == TIW_STANDBY) && wake_hit |=> cpu_clk_en ##1 cpu_clk_en) // RL14
    else $error("wake did not restart the clock");
  a_wdt_fire: assert property (wdt_expire && !wdog_clr |=> wdt_reset ##1 !wdt_reset) // RL17
    else $error("watchdog expiry missed");

  // Non-maskable line follows its enabled pending flag one cycle later
  a_nmi_raise: assert property (pend[TIW_NMI_BIT] && irq_en[TIW_NMI_BIT] |=> nmi_req) // RL7
    else $error("non-maskable request not raised");
  a_ext_gate: assert property (pin_rise[TIW_PIN_EXT] && !ctrl[TIW_CTRL_EXT_EN] |-> !pend_set[TIW_IRQ_EXT]) // RL10
    else $error("external request while disabled");
  a_osc_weak: assert property (ctrl[TIW_CTRL_AUTO] && strong_done |=> !osc_strong) // RL16
    else $error("crystal drive stayed strong");
  a_io_hold: assert property (pwr_state == TIW_STANDBY |-> io_hold && !cpu_clk_en) // RL12
    else $error("standby lost hold");
  a_tick_pend: assert property (rtc_event |=> pend[5]) // RL15
    else $error("tick did not set its flag");

endmodule

// ### rtl/tiw_pkg.sv
// Package: register map, field layout, reset values and timing constants of the timer block
package tiw_pkg;

  // ==========================================================================
  // Widths
  localparam int TIW_TW = 12;
  localparam int TIW_DW = 16;
  localparam int TIW_AW = 4;
  localparam int TIW_SYNC_W = 11;

  // ==========================================================================
  // Register offsets (word index on the register port)
  localparam logic [3:0] TIW_REG_TMA = 4'h0;
  localparam logic [3:0] TIW_REG_TMB = 4'h1;
  localparam logic [3:0] TIW_REG_TMC = 4'h2;
  localparam logic [3:0] TIW_REG_INTEN = 4'h3;
  localparam logic [3:0] TIW_REG_PEND = 4'h4;
  localparam logic [3:0] TIW_REG_CTRL = 4'h5;
  localparam logic [3:0] TIW_REG_WAKE = 4'h6;
  localparam logic [3:0] TIW_REG_STOP = 4'h7;
  localparam logic [3:0] TIW_REG_WDOG = 4'h8;
  localparam logic [3:0] TIW_REG_STAT = 4'h9;

  // ==========================================================================
  // Reset values and the timer terminal count
  localparam logic [15:0] TIW_CTRL_RST = 16'h0000;
  localparam logic [2:0] TIW_WAKE_RST = 3'h0;
  localparam logic [8:0] TIW_INTEN_RST = 9'h000;
  localparam logic [11:0] TIW_TMR_RST = 12'h000;
  localparam logic [11:0] TIW_TMR_MAX = 12'hFFF;

  // ==========================================================================
  // Control register fields
  localparam int TIW_CTRL_RUN_A = 0;
  localparam int TIW_CTRL_RUN_B = 1;
  localparam int TIW_CTRL_RUN_C = 2;
  localparam int TIW_CTRL_ECK = 3;
  localparam int TIW_CTRL_RTC8 = 4;
  localparam int TIW_CTRL_AUTO = 5;
  localparam int TIW_CTRL_EXT_EN = 6;

  // Wake-up enable fields
  localparam int TIW_WAKE_KEY = 0;
  localparam int TIW_WAKE_RTC = 1;
  localparam int TIW_WAKE_EXT = 2;

  // Interrupt lines: bit n is request line n+1, bit 8 the non-maskable line
  localparam int TIW_IRQ_TMA = 0;
  localparam int TIW_IRQ_EXT = 7;
  localparam int TIW_NMI_BIT = 8;

  // Pin synchroniser lanes
  localparam int TIW_PIN_EXT = 8;
  localparam int TIW_PIN_ECK = 9;
  localparam int TIW_PIN_XTAL = 10;

  // ==========================================================================
  // Crystal divider taps, in crystal edges
  localparam logic [13:0] TIW_TB1_MASK = 14'h007F;
  localparam logic [13:0] TIW_TB2_MASK = 14'h07FF;
  localparam logic [13:0] TIW_RTC8_MASK = 14'h0FFF;
  localparam logic [13:0] TIW_RTC2_MASK = 14'h3FFF;

  // ==========================================================================
  // Timing
  localparam longint TIW_CLK_HZ = 250_000_000;
  localparam longint TIW_XTAL_HZ = 32768;
  localparam longint TIW_WDT_MS = 1000;
  localparam longint TIW_OSC_STRONG_MS = 1000;
  localparam int unsigned TIW_WDT_CYCLES = int'(TIW_CLK_HZ * TIW_WDT_MS / 1000);
  localparam int unsigned TIW_OSC_STRONG_EDGES = int'(TIW_XTAL_HZ * TIW_OSC_STRONG_MS / 1000);

  // Power states
  typedef enum logic [0:0] {
    TIW_RUN = 1'b0,
    TIW_STANDBY = 1'b1
  } tiw_pwr_t;

endpackage

// ### verif/tiw_cpu_model.sv
// Processor-side model: enters and leaves non-maskable service with one-cycle pulses
module tiw_cpu_model #(
  parameter int SVC = 30
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic nmi_req,
  output logic nmi_ack,
  output logic nmi_done,
  output logic in_service
);
  timeunit 1ns;
  timeprecision 100ps;
  logic req_q;
  int cnt;

  // ==========================================================================
  // Service starts on a new request only, so a request left high is not re-entered
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_q <= 1'b0;
      nmi_ack <= 1'b0;
      nmi_done <= 1'b0;
      in_service <= 1'b0;
      cnt <= 0;
    end else begin
      req_q <= nmi_req;
      nmi_ack <= 1'b0;
      nmi_done <= 1'b0;
      if (nmi_req && !req_q && !in_service) begin
        nmi_ack <= 1'b1;
        in_service <= 1'b1;
        cnt <= SVC;
      end else if (in_service && cnt == 0) begin
        nmi_done <= 1'b1;
        in_service <= 1'b0;
      end else if (in_service) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ### verif/timers_interrupts_wakeup_tb.sv
// Self-checking bench for the timer, interrupt, standby and watchdog block
module timers_interrupts_wakeup_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import tiw_pkg::*;
  logic clock, rst, reg_wr, reg_rd, irq_req, nmi_req, cpu_clk_en, io_hold, osc_strong, wdt_reset;
  logic port_a_bit0_pin, port_a_bit1_pin, xtal_32k_in, nmi_ack, nmi_done, in_service, wd_seen;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pd, v0, v1;
  logic [7:0] key_pins;
  logic [2:0] irq_num;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  int n;

  // ==========================================================================
  // Short watchdog and oscillator counts keep the run brief
  tiw_top #(.WDT_CYCLES(64), .OSC_STRONG_EDGES(8)) i_dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_pins(key_pins), .port_a_bit0_pin(port_a_bit0_pin),
    .port_a_bit1_pin(port_a_bit1_pin), .xtal_32k_in(xtal_32k_in), .nmi_ack(nmi_ack), .nmi_done(nmi_done),
    .irq_req(irq_req), .irq_num(irq_num), .nmi_req(nmi_req), .cpu_clk_en(cpu_clk_en), .io_hold(io_hold),
    .osc_strong(osc_strong), .wdt_reset(wdt_reset));
  tiw_cpu_model #(.SVC(30)) i_cpu (.clock(clock), .rst(rst), .nmi_req(nmi_req), .nmi_ack(nmi_ack),
    .nmi_done(nmi_done), .in_service(in_service));

  // ==========================================================================
  // Crystal period is no multiple of the system period, so phases drift
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    xtal_32k_in = 1'b0;
    forever #16.3 xtal_32k_in = ~xtal_32k_in;
  end
  // Hang guard and watchdog pulse monitor
  always @(posedge clock) begin
    cycles++;
    if (wdt_reset === 1'b1) wd_seen = 1'b1;
    if (cycles == 90000) begin
      failures++;
      conclude();
    end
  end

  // ==========================================================================
  // Access tasks: strobes rise after an edge and drop after the taking edge
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask
  task automatic wait_pend(input logic [15:0] m);
    pd = 16'h0000;
    for (int i = 0; i < 10000 && (pd & m) !== m; i++) rd(TIW_REG_PEND, pd);
  endtask
  task automatic wait_run(input int lim);
    for (int i = 0; i < lim && cpu_clk_en !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    key_pins = 8'h00;
    port_a_bit0_pin = 1'b0;
    port_a_bit1_pin = 1'b0;
    wd_seen = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    // Reset state, defaults, unmapped place and a refused stop
    chk("run after reset", {14'h0000, cpu_clk_en, osc_strong}, 16'h0003);
    rd(TIW_REG_CTRL, v0);
    chk("ctrl", v0, TIW_CTRL_RST);
    rd(TIW_REG_INTEN, v0);
    chk("enable", v0, 16'(TIW_INTEN_RST));
    rd(4'hF, v0);
    chk("unmapped", v0, 16'h0000);
    wr(TIW_REG_STOP, 16'h0000);
    #1 chk("stop refused", 16'(cpu_clk_en), 16'h0001);
    // Timers b and c: reload, live reads, masking, sticky flags, priority
    wr(TIW_REG_TMB, 16'h0000);
    wr(TIW_REG_TMC, 16'h0000);
    wr(TIW_REG_TMB, 16'h0F00);
    wr(TIW_REG_CTRL, 16'h0006);
    // The slower time base needs 2048 crystal edges, so wait for it too
    wait_pend(16'h001E);
    chk("masked irq", 16'(irq_req), 16'h0000);
    chk("time bases", pd & 16'h0018, 16'h0018);
    chk("strong not auto", 16'(osc_strong), 16'h0001);
    rd(TIW_REG_TMB, v0);
    chk("reload", 16'(v0[11:8]), 16'h000F);
    rd(TIW_REG_TMC, v0);
    rd(TIW_REG_TMC, v1);
    chk("live read", v1 - v0, 16'h0002);
    wr(TIW_REG_CTRL, 16'h0000);
    wr(TIW_REG_INTEN, 16'h0006);
    repeat (3) @(posedge clock);
    #1 chk("irq line2", {12'h000, irq_req, irq_num}, 16'h0009);
    wr(TIW_REG_PEND, 16'h0002);
    repeat (3) @(posedge clock);
    #1 chk("irq line3", {12'h000, irq_req, irq_num}, 16'h000A);
    wr(TIW_REG_INTEN, 16'h0000);
    rd(TIW_REG_PEND, pd);
    chk("sticky", pd & 16'h0006, 16'h0004);
    chk("masked off", 16'(irq_req), 16'h0000);
    wr(TIW_REG_TMC, 16'h0000);
    rd(TIW_REG_TMC, v0);
    chk("zero write", v0, 16'h0000);
    // Timer a counts external clock edges
    wr(TIW_REG_TMA, 16'h0000);
    wr(TIW_REG_CTRL, 16'h0009);
    repeat (5) begin
      port_a_bit1_pin <= 1'b1;
      repeat (6) @(posedge clock);
      port_a_bit1_pin <= 1'b0;
      repeat (6) @(posedge clock);
    end
    rd(TIW_REG_TMA, v0);
    chk("ext clock count", v0, 16'h0005);
    // Timer a overflow: non-maskable service holds off maskable line 1
    wr(TIW_REG_CTRL, 16'h0001);
    wr(TIW_REG_TMA, 16'h0000);
    wait_pend(16'h0101);
    wr(TIW_REG_CTRL, 16'h0000);
    wr(TIW_REG_INTEN, 16'h0101);
    for (n = 0; n < 20 && in_service !== 1'b1; n++) @(posedge clock);
    repeat (3) @(posedge clock);
    #1 chk("nmi service", {14'h0000, in_service, irq_req}, 16'h0002);
    wr(TIW_REG_PEND, 16'h0100);
    for (n = 0; n < 40 && in_service === 1'b1; n++) @(posedge clock);
    repeat (3) @(posedge clock);
    #1 chk("after nmi", {12'h000, irq_req, irq_num}, 16'h0008);
    wr(TIW_REG_INTEN, 16'h0000);
    wr(TIW_REG_PEND, 16'h01FF);
    // Watchdog: regular clears hold it off, then one expiry is timed
    wr(TIW_REG_WDOG, 16'h0000);
    #1 wd_seen = 1'b0;
    repeat (4) begin
      repeat (38) @(posedge clock);
      wr(TIW_REG_WDOG, 16'h0000);
    end
    chk("no expiry", 16'(wd_seen), 16'h0000);
    wr(TIW_REG_WDOG, 16'h0000);
    #1;
    for (n = 1; n < 200 && wdt_reset !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    chk("expiry time", 16'(n >= 62 && n <= 65), 16'h0001);
    // Standby entered, held, then left on a key change
    wr(TIW_REG_WAKE, 16'h0001);
    wr(TIW_REG_STOP, 16'h0000);
    #1 chk("standby", {14'h0000, cpu_clk_en, io_hold}, 16'h0001);
    repeat (20) @(posedge clock);
    #1 chk("standby held", {14'h0000, cpu_clk_en, io_hold}, 16'h0001);
    key_pins <= 8'h01;
    wait_run(20);
    chk("key wake", {14'h0000, cpu_clk_en, io_hold}, 16'h0002);
    rd(TIW_REG_PEND, pd);
    chk("key flag", pd & 16'h0040, 16'h0040);
    // External pin wakes and requests line 8
    wr(TIW_REG_CTRL, 16'h0040);
    wr(TIW_REG_INTEN, 16'h0080);
    wr(TIW_REG_WAKE, 16'h0004);
    wr(TIW_REG_STOP, 16'h0000);
    port_a_bit0_pin <= 1'b1;
    wait_run(20);
    repeat (4) @(posedge clock);
    #1 chk("ext wake", {11'h000, cpu_clk_en, irq_req, irq_num}, 16'h001F);
    wr(TIW_REG_INTEN, 16'h0000);
    // The 8 Hz tick wakes; auto mode has weakened the crystal by then
    wr(TIW_REG_CTRL, 16'h0030);
    wr(TIW_REG_WAKE, 16'h0002);
    wr(TIW_REG_PEND, 16'h01FF);
    wr(TIW_REG_STOP, 16'h0000);
    #1 chk("tick standby", 16'(cpu_clk_en), 16'h0000);
    wait_run(36000);
    chk("tick wake", {14'h0000, cpu_clk_en, osc_strong}, 16'h0002);
    rd(TIW_REG_PEND, pd);
    chk("tick flag", pd & 16'h0020, 16'h0020);
    conclude();
  end
endmodule
